// ==== verilog/osau_unit.sv ====
// Top: operand specifier decoder and address unit
// Function
// RL1 - Software must not use stack pointer for two-register operand.
// RL2 - Word writes to a register replace only the low half.
// RL3 - Mode 6: register contents are the operand address.
// RL4 - Software must not use program counter in register deferred mode.
// RL5 - Operand size steps: byte 1, word 2, long 4, quad 8.
// RL6 - Mode 8: register is address, then register plus size written.
// RL7 - Mode 8 with program counter means immediate operand in stream.
// RL8 - Mode 9: fetch longword address at register, register plus 4.
// RL9 - Mode 9 with program counter means absolute address from stream.
// RL10 - Mode 7: register minus size written back, new value is address.
// RL11 - Software must not use program counter in autodecrement mode.
// RL12 - Mode fields 0 to 3 give short literal 0..63, no memory.
// RL13 - Literal recognised by bits 7,6 zero; value in six low bits.
// RL14 - Constants above 63 must be coded as immediate operands.
// RL15 - Multi-byte memory operands occupy consecutive bytes upward.
// RL16 - Word load: addressed byte lowest, next byte above it.
// RL17 - Mode 5: operand is register, or pair with next register above.
// RL18 - Register mode with address access faults as illegal mode.
// RL19 - Short literal with non-read access faults as reserved mode.
// RL20 - Mode in upper four bits, register number in lower four.
module osau_unit
    import osau_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire osau_req_t req,
    input wire logic [31:0] gpr_rd_data,
    input wire logic [31:0] gpr_rd_hi_data,
    input wire logic wb_valid,
    input wire logic [3:0] wb_num,
    input wire logic [31:0] wb_data,
    input wire logic wb_word,
    input wire logic mem_ack,
    input wire logic [7:0] mem_byte,
    output logic busy_r,
    output logic ans_valid_r,
    output osau_ans_t ans_r,
    output logic [3:0] gpr_rd_num_r,
    output osau_gpr_wr_t gpr_wr_r,
    output logic mem_req_r,
    output logic [31:0] mem_addr_r
);

    ////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [31:0] size_bytes(input osau_size_t s);
        unique case (s)
            OSAU_SIZE_B: size_bytes = {28'h0, OSAU_SZ_BYTE}; // RL5
            OSAU_SIZE_W: size_bytes = {28'h0, OSAU_SZ_WORD}; // RL5
            OSAU_SIZE_L: size_bytes = {28'h0, OSAU_SZ_LONG}; // RL5
            OSAU_SIZE_Q: size_bytes = {28'h0, OSAU_SZ_QUAD}; // RL5
        endcase
    endfunction : size_bytes

    // Word write keeps the upper half of the destination
    function automatic logic [31:0] merge_word(input logic [31:0] old,
                                               input logic [31:0] nw);
        merge_word = {old[31:16], nw[15:0]}; // RL2
    endfunction : merge_word

    ////////////////////////////////////////////////////////////////////
    // State machine

    typedef enum logic [2:0] {
        OSAU_ST_IDLE = 3'b000,
        OSAU_ST_READ = 3'b001,
        OSAU_ST_EXEC = 3'b011,
        OSAU_ST_PTR = 3'b010,
        OSAU_ST_MERGE = 3'b110
    } osau_state_t;

    osau_state_t state_r;
    osau_state_t state_nxt;
    osau_req_t req_r;
    logic [31:0] wb_data_r;
    logic [3:0] wb_num_r;
    logic [3:0] spec_mode;
    logic [3:0] spec_reg;
    logic is_lit;
    logic is_pc;
    logic mw_start;
    logic mw_done;
    logic mw_req;
    logic [31:0] mw_addr;
    logic [63:0] mw_data;

    assign is_lit = (req_r.spec[7:6] == OSAU_LIT_TAG); // RL13
    assign spec_mode = req_r.spec[7:4]; // RL20
    assign spec_reg = req_r.spec[3:0]; // RL20
    assign is_pc = (spec_reg == OSAU_PC_NUM);
    assign mw_start = (state_r == OSAU_ST_EXEC) && !is_lit
        && (spec_mode == OSAU_MODE_INCDEF) && !is_pc;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            OSAU_ST_IDLE:
                // A register write in the same cycle wins over a request
                if (req_valid && !wb_valid)
                    state_nxt = OSAU_ST_READ;
            OSAU_ST_READ:
                state_nxt = OSAU_ST_EXEC;
            OSAU_ST_EXEC:
                state_nxt = mw_start ? OSAU_ST_PTR : OSAU_ST_IDLE;
            OSAU_ST_PTR:
                if (mw_done)
                    state_nxt = OSAU_ST_IDLE;
            OSAU_ST_MERGE:
                state_nxt = OSAU_ST_IDLE;
            default:
                state_nxt = OSAU_ST_IDLE;
        endcase
    end

    // Busy is kept as its own flop so that the port comes from a register
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= OSAU_ST_IDLE;
            busy_r <= 1'b0;
        end
        else if (wb_valid && wb_word && state_r == OSAU_ST_IDLE)
        begin
            state_r <= OSAU_ST_MERGE;
            busy_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            busy_r <= (state_nxt != OSAU_ST_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Request capture and register file read port

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_r <= '0;
            gpr_rd_num_r <= '0;
            wb_data_r <= '0;
            wb_num_r <= '0;
        end
        else if (state_r == OSAU_ST_IDLE)
        begin
            if (wb_valid && wb_word)
            begin
                wb_data_r <= wb_data;
                wb_num_r <= wb_num;
                gpr_rd_num_r <= wb_num;
            end
            else if (req_valid && !wb_valid)
            begin
                req_r <= req;
                gpr_rd_num_r <= req.spec[3:0]; // RL20
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Answer and base register update

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ans_valid_r <= 1'b0;
            ans_r <= '0;
            gpr_wr_r <= '0;
        end
        else
        begin
            ans_valid_r <= 1'b0;
            gpr_wr_r.we <= 1'b0;
            if (state_r == OSAU_ST_IDLE && wb_valid && !wb_word)
            begin
                gpr_wr_r.we <= 1'b1;
                gpr_wr_r.num <= wb_num;
                gpr_wr_r.data <= wb_data;
            end
            else if (state_r == OSAU_ST_MERGE)
            begin
                gpr_wr_r.we <= 1'b1;
                gpr_wr_r.num <= wb_num_r;
                gpr_wr_r.data <= merge_word(gpr_rd_data, wb_data_r); // RL2
            end
            else if (state_r == OSAU_ST_EXEC)
            begin
                ans_r.reg_num <= spec_reg;
                ans_r.pair <= 1'b0;
                ans_valid_r <= !mw_start;
                if (is_lit)
                begin
                    ans_r.value <= {26'h0, req_r.spec[5:0]}; // RL12
                    ans_r.kind <= (req_r.acc == OSAU_ACC_R)
                        ? OSAU_RES_LIT : OSAU_RES_RSVD; // RL19
                end
                else
                begin
                    unique case (spec_mode)
                        OSAU_MODE_REG:
                        begin
                            ans_r.value <= gpr_rd_data; // RL17
                            ans_r.pair <= (req_r.size == OSAU_SIZE_Q); // RL17
                            ans_r.kind <= (req_r.acc == OSAU_ACC_A)
                                ? OSAU_RES_ILL : OSAU_RES_REG; // RL18
                        end
                        OSAU_MODE_DEF:
                        begin
                            ans_r.value <= gpr_rd_data; // RL3
                            ans_r.kind <= OSAU_RES_ADDR;
                        end
                        OSAU_MODE_DEC:
                        begin
                            ans_r.value <= gpr_rd_data
                                - size_bytes(req_r.size); // RL10
                            ans_r.kind <= OSAU_RES_ADDR;
                            gpr_wr_r.we <= 1'b1;
                            gpr_wr_r.num <= spec_reg;
                            gpr_wr_r.data <= gpr_rd_data
                                - size_bytes(req_r.size); // RL10
                        end
                        OSAU_MODE_INC:
                        begin
                            ans_r.value <= gpr_rd_data; // RL6
                            ans_r.kind <= is_pc
                                ? OSAU_RES_IMM : OSAU_RES_ADDR; // RL7
                            gpr_wr_r.we <= 1'b1;
                            gpr_wr_r.num <= spec_reg;
                            gpr_wr_r.data <= gpr_rd_data
                                + size_bytes(req_r.size); // RL6
                        end
                        OSAU_MODE_INCDEF:
                        begin
                            // Program counter: absolute address in stream
                            ans_r.value <= gpr_rd_data; // RL9
                            ans_r.kind <= is_pc
                                ? OSAU_RES_IMM : OSAU_RES_ADDR; // RL9
                            gpr_wr_r.we <= 1'b1;
                            gpr_wr_r.num <= spec_reg;
                            gpr_wr_r.data <= gpr_rd_data
                                + OSAU_PTR_STEP; // RL8
                        end
                        default:
                        begin
                            ans_r.value <= '0;
                            ans_r.kind <= OSAU_RES_RSVD;
                        end
                    endcase
                end
            end
            else if (state_r == OSAU_ST_PTR && mw_done)
            begin
                ans_valid_r <= 1'b1;
                ans_r.kind <= OSAU_RES_ADDR;
                ans_r.value <= mw_data[31:0]; // RL8
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pointer fetch from byte memory

    osau_mem_word u_mem_word (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .start(mw_start),
        .base(gpr_rd_data),
        .nbytes(OSAU_SZ_LONG),
        .rd_ack(mem_ack),
        .rd_byte(mem_byte),
        .rd_req_r(mw_req),
        .rd_addr_r(mw_addr),
        .done_r(mw_done),
        .data_r(mw_data)
    );

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mem_req_r <= 1'b0;
            mem_addr_r <= '0;
        end
        else
        begin
            mem_req_r <= mw_req && !(mem_ack && mem_req_r);
            mem_addr_r <= mw_addr;
        end
    end

endmodule : osau_unit

// ==== verilog/osau_pkg.sv ====
// Package: constants and carriers for the operand specifier address unit
package osau_pkg;

    localparam int unsigned OSAU_DW = 32;
    localparam logic [3:0] OSAU_MODE_REG = 4'h5;
    localparam logic [3:0] OSAU_MODE_DEF = 4'h6;
    localparam logic [3:0] OSAU_MODE_DEC = 4'h7;
    localparam logic [3:0] OSAU_MODE_INC = 4'h8;
    localparam logic [3:0] OSAU_MODE_INCDEF = 4'h9;
    localparam logic [3:0] OSAU_PC_NUM = 4'hf;
    localparam logic [3:0] OSAU_SP_NUM = 4'he;
    localparam logic [1:0] OSAU_LIT_TAG = 2'h0;
    localparam logic [31:0] OSAU_PTR_STEP = 32'h0000_0004;
    localparam logic [3:0] OSAU_SZ_BYTE = 4'h1;
    localparam logic [3:0] OSAU_SZ_WORD = 4'h2;
    localparam logic [3:0] OSAU_SZ_LONG = 4'h4;
    localparam logic [3:0] OSAU_SZ_QUAD = 4'h8;
    localparam logic [2:0] OSAU_LAST_BYTE_QUAD = 3'h7;

    // Operand size code
    typedef enum logic [1:0] {
        OSAU_SIZE_B = 2'h0,
        OSAU_SIZE_W = 2'h1,
        OSAU_SIZE_L = 2'h2,
        OSAU_SIZE_Q = 2'h3
    } osau_size_t;

    // Access type of the operand
    typedef enum logic [2:0] {
        OSAU_ACC_R = 3'h0,
        OSAU_ACC_M = 3'h1,
        OSAU_ACC_W = 3'h2,
        OSAU_ACC_A = 3'h3,
        OSAU_ACC_V = 3'h4
    } osau_acc_t;

    // Result kind delivered with a completed specifier
    typedef enum logic [2:0] {
        OSAU_RES_LIT = 3'h0,
        OSAU_RES_REG = 3'h1,
        OSAU_RES_ADDR = 3'h2,
        OSAU_RES_IMM = 3'h3,
        OSAU_RES_RSVD = 3'h4,
        OSAU_RES_ILL = 3'h5
    } osau_res_t;

    typedef struct packed {
        logic [7:0] spec;
        osau_size_t size;
        osau_acc_t acc;
    } osau_req_t;

    typedef struct packed {
        osau_res_t kind;
        logic [3:0] reg_num;
        logic pair;
        logic [31:0] value;
    } osau_ans_t;

    typedef struct packed {
        logic we;
        logic [3:0] num;
        logic [31:0] data;
    } osau_gpr_wr_t;

endpackage : osau_pkg

// ==== verilog/osau_mem_word.sv ====
// Memory word assembler: gathers consecutive bytes little-endian
module osau_mem_word
    import osau_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [31:0] base,
    input wire logic [3:0] nbytes,
    input wire logic rd_ack,
    input wire logic [7:0] rd_byte,
    output logic rd_req_r,
    output logic [31:0] rd_addr_r,
    output logic done_r,
    output logic [63:0] data_r
);

    logic [3:0] idx_r;
    logic [3:0] cnt_r;

    // Walk consecutive addresses, byte k lands at bits 8k+7:8k
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_req_r <= 1'b0;
            rd_addr_r <= '0;
            idx_r <= '0;
            cnt_r <= '0;
            done_r <= 1'b0;
            data_r <= '0;
        end
        else
        begin
            done_r <= 1'b0;
            if (start)
            begin
                rd_req_r <= 1'b1; // RL15
                rd_addr_r <= base;
                idx_r <= '0;
                cnt_r <= nbytes;
                data_r <= '0;
            end
            else if (rd_req_r && rd_ack)
            begin
                data_r[idx_r[2:0]*8 +: 8] <= rd_byte; // RL16
                if (idx_r + 4'h1 == cnt_r)
                begin
                    rd_req_r <= 1'b0;
                    done_r <= 1'b1;
                end
                else
                begin
                    idx_r <= idx_r + 4'h1;
                    rd_addr_r <= rd_addr_r + 32'h0000_0001; // RL15
                end
            end
        end
    end

endmodule : osau_mem_word

// ==== test/osau_unit_assertions.sv ====
// Checker: port-level properties of the operand specifier address unit
module osau_unit_checker
    import osau_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic req_valid,
    input wire osau_req_t req,
    input wire logic wb_valid,
    input wire logic busy_r,
    input wire logic ans_valid_r,
    input wire osau_ans_t ans_r,
    input wire osau_gpr_wr_t gpr_wr_r
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    osau_req_t req_q_r;
    logic take, lit, pc, rd, ans5, ans8, ans7;
    logic [3:0] mode;
    logic [31:0] step;
    assign take = req_valid && !busy_r && !wb_valid;
    assign mode = req_q_r.spec[7:4];
    assign lit = req_q_r.spec[7:6] == OSAU_LIT_TAG;
    assign pc = req_q_r.spec[3:0] == OSAU_PC_NUM;
    assign rd = req_q_r.acc == OSAU_ACC_R;
    assign ans5 = ans_valid_r && mode == OSAU_MODE_REG;
    assign ans7 = ans_valid_r && mode == OSAU_MODE_DEC;
    assign ans8 = ans_valid_r && mode == OSAU_MODE_INC && !pc;
    assign step = 32'h1 << req_q_r.size;

    // Request seen at the take edge, judged when its answer appears
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            req_q_r <= '0;
        else if (take)
            req_q_r <= req;
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_take;
        req_valid && !busy_r && !wb_valid;
    endsequence
    sequence s_take_short;
        s_take ##0 req.spec[7:4] != OSAU_MODE_INCDEF;
    endsequence

    a_short_latency: assert property (s_take_short |-> ##3 ans_valid_r)
        else $error("answer not three cycles after request");
    a_answer_pulse: assert property (ans_valid_r |=> !ans_valid_r)
        else $error("answer strobe longer than one cycle");
    a_take_busy: assert property (s_take |=> busy_r)
        else $error("unit not busy after taking request");
    a_lit_value: assert property (ans_valid_r && lit && rd |->
        ans_r.kind == OSAU_RES_LIT && ans_r.value == {26'h0, req_q_r.spec[5:0]})
        else $error("short literal answer wrong");
    a_lit_fault: assert property (ans_valid_r && lit && !rd |->
        ans_r.kind == OSAU_RES_RSVD)
        else $error("literal with non-read access not refused");
    a_reg_fault: assert property (ans5 && req_q_r.acc == OSAU_ACC_A |->
        ans_r.kind == OSAU_RES_ILL)
        else $error("register mode address access not refused");
    a_reg_operand: assert property (ans5 && req_q_r.acc != OSAU_ACC_A |->
        ans_r.kind == OSAU_RES_REG && ans_r.reg_num == req_q_r.spec[3:0]
        && ans_r.pair == (req_q_r.size == OSAU_SIZE_Q))
        else $error("register mode answer wrong");
    a_inc_step: assert property (ans8 |-> gpr_wr_r.we &&
        gpr_wr_r.num == req_q_r.spec[3:0] && gpr_wr_r.data == ans_r.value + step)
        else $error("autoincrement write-back wrong");
    a_dec_step: assert property (ans7 |-> gpr_wr_r.we &&
        gpr_wr_r.num == req_q_r.spec[3:0] && gpr_wr_r.data == ans_r.value)
        else $error("autodecrement write-back wrong");
    a_pc_forms: assert property (ans_valid_r && pc &&
        (mode == OSAU_MODE_INC || mode == OSAU_MODE_INCDEF)
        |-> ans_r.kind == OSAU_RES_IMM)
        else $error("program counter form not immediate");
endmodule : osau_unit_checker

bind osau_unit osau_unit_checker chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .req_valid(req_valid), .req(req), .wb_valid(wb_valid), .busy_r(busy_r),
    .ans_valid_r(ans_valid_r), .ans_r(ans_r), .gpr_wr_r(gpr_wr_r));

// ==== test/osau_partner.sv ====
// Partner model: general register file and byte memory
module osau_partner
    import osau_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [3:0] gpr_rd_num_r,
    input wire osau_gpr_wr_t gpr_wr_r,
    input wire logic mem_req_r,
    input wire logic [31:0] mem_addr_r,
    input wire logic [1:0] mem_delay,
    output logic [31:0] gpr_rd_data,
    output logic mem_ack,
    output logic [7:0] mem_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] regs [16];
    logic pend = 1'b0;
    logic [1:0] cnt = 2'h0;
    logic [31:0] addr_l = 32'h0;

    assign gpr_rd_data = regs[gpr_rd_num_r];
    initial
    begin
        foreach (regs[i])
            regs[i] = 32'h0;
        mem_ack = 1'b0;
        mem_byte = 8'h00;
    end

    // Byte reads answered after a chosen number of idle cycles
    always @(posedge ref_clk)
    begin
        if (gpr_wr_r.we)
            regs[gpr_wr_r.num] <= gpr_wr_r.data;
        mem_ack <= 1'b0;
        mem_byte <= ~mem_byte;
        if (pend && cnt == mem_delay)
        begin
            mem_ack <= 1'b1;
            mem_byte <= addr_l[7:0] ^ addr_l[15:8] ^ 8'h3c;
            pend <= 1'b0;
        end
        else if (pend)
            cnt <= cnt + 2'h1;
        else if (mem_req_r && !mem_ack)
        begin
            pend <= 1'b1;
            cnt <= 2'h0;
            addr_l <= mem_addr_r;
        end
    end
endmodule : osau_partner

// ==== test/osau_unit_test.sv ====
// Testbench: operand specifier address unit against the partner model
module osau_unit_test
    import osau_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req_valid = 1'b0;
    osau_req_t req = '0;
    logic wb_valid = 1'b0;
    logic [3:0] wb_num = 4'h0;
    logic [31:0] wb_data = 32'h0;
    logic wb_word = 1'b0;
    logic [1:0] mem_delay = 2'h0;
    logic mem_ack, busy_r, ans_valid_r, mem_req_r;
    logic [7:0] mem_byte;
    logic [31:0] gpr_rd_data, mem_addr_r;
    logic [3:0] gpr_rd_num_r;
    osau_ans_t ans_r;
    osau_gpr_wr_t gpr_wr_r;
    int miscompares = 0;
    int samples_checked = 0;

    always #5 ref_clk = ~ref_clk;

    osau_unit uut (.ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid),
        .req(req), .gpr_rd_data(gpr_rd_data), .gpr_rd_hi_data(32'h0),
        .wb_valid(wb_valid), .wb_num(wb_num), .wb_data(wb_data),
        .wb_word(wb_word), .mem_ack(mem_ack), .mem_byte(mem_byte),
        .busy_r(busy_r), .ans_valid_r(ans_valid_r), .ans_r(ans_r),
        .gpr_rd_num_r(gpr_rd_num_r), .gpr_wr_r(gpr_wr_r),
        .mem_req_r(mem_req_r), .mem_addr_r(mem_addr_r));
    osau_partner mdl (.ref_clk(ref_clk), .gpr_rd_num_r(gpr_rd_num_r),
        .gpr_wr_r(gpr_wr_r), .mem_req_r(mem_req_r), .mem_addr_r(mem_addr_r),
        .mem_delay(mem_delay), .gpr_rd_data(gpr_rd_data),
        .mem_ack(mem_ack), .mem_byte(mem_byte));

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compares %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic guard(input int n);
        if (n >= 200)
        begin
            miscompares++;
            $display("ERROR %0t: wait ran out", $time);
            wrap_up();
        end
    endtask : guard

    task automatic wait_idle();
        int n;
        for (n = 0; n < 200; n++)
        begin
            @(negedge ref_clk);
            if (busy_r === 1'b0)
                break;
        end
        guard(n);
        @(posedge ref_clk);
    endtask : wait_idle

    // One request, held for one take edge, then the answer awaited
    task automatic issue(input logic [7:0] sp, input osau_size_t sz,
                         input osau_acc_t ac);
        int n;
        wait_idle();
        req_valid <= 1'b1;
        req <= '{spec: sp, size: sz, acc: ac};
        @(posedge ref_clk);
        req_valid <= 1'b0;
        for (n = 0; n < 200; n++)
        begin
            @(posedge ref_clk);
            #1;
            if (ans_valid_r === 1'b1)
                break;
        end
        guard(n);
        @(posedge ref_clk);
        #1;
    endtask : issue

    task automatic reg_write(input logic [31:0] d, input logic word);
        int n;
        wait_idle();
        wb_valid <= 1'b1;
        wb_num <= 4'h2;
        wb_data <= d;
        wb_word <= word;
        @(posedge ref_clk);
        wb_valid <= 1'b0;
        for (n = 0; n < 200; n++)
        begin
            #1;
            if (gpr_wr_r.we === 1'b1)
                break;
            @(posedge ref_clk);
        end
        guard(n);
        @(posedge ref_clk);
        #1;
    endtask : reg_write

    function automatic logic [7:0] mb(input logic [31:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction : mb

    ////////////////////////////////////////////////////////////////////////
    task automatic t_literal();
        for (int i = 0; i < 4; i++)
        begin
            issue({2'h0, 6'(i * 21)}, OSAU_SIZE_L, OSAU_ACC_R);
            check(32'(ans_r.kind), 32'(OSAU_RES_LIT));
            check(ans_r.value, 32'(i * 21));
        end
        for (int a = 1; a < 5; a++)
        begin
            issue(8'h09, OSAU_SIZE_L, osau_acc_t'(a));
            check(32'(ans_r.kind), 32'(OSAU_RES_RSVD));
        end
    endtask : t_literal

    task automatic t_register();
        issue({OSAU_MODE_REG, 4'h3}, OSAU_SIZE_L, OSAU_ACC_M);
        check(32'(ans_r.kind), 32'(OSAU_RES_REG));
        check({ans_r.reg_num, 3'h0, ans_r.pair}, 32'h30);
        issue({OSAU_MODE_REG, 4'hd}, OSAU_SIZE_Q, OSAU_ACC_R);
        check({ans_r.reg_num, 3'h0, ans_r.pair}, 32'hd1);
        issue({OSAU_MODE_REG, 4'h3}, OSAU_SIZE_L, OSAU_ACC_A);
        check(32'(ans_r.kind), 32'(OSAU_RES_ILL));
        mdl.regs[4] = 32'h0000_1010;
        issue({OSAU_MODE_DEF, 4'h4}, OSAU_SIZE_Q, OSAU_ACC_W);
        check(32'(ans_r.kind), 32'(OSAU_RES_ADDR));
        check(ans_r.value, 32'h0000_1010);
        check(mdl.regs[4], 32'h0000_1010);
    endtask : t_register

    task automatic t_step();
        logic [31:0] sz;
        for (int s = 0; s < 4; s++)
        begin
            sz = 32'h1 << s;
            mdl.regs[2] = 32'h0000_2000;
            issue({OSAU_MODE_INC, 4'h2}, osau_size_t'(s), OSAU_ACC_R);
            check(ans_r.value, 32'h0000_2000);
            check(mdl.regs[2], 32'h0000_2000 + sz);
            mdl.regs[3] = 32'h0000_1018;
            issue({OSAU_MODE_DEC, 4'h3}, osau_size_t'(s), OSAU_ACC_W);
            check(ans_r.value, 32'h0000_1018 - sz);
            check(mdl.regs[3], 32'h0000_1018 - sz);
        end
    endtask : t_step

    task automatic t_pc();
        mdl.regs[15] = 32'h0000_3001;
        issue({OSAU_MODE_INC, OSAU_PC_NUM}, OSAU_SIZE_L, OSAU_ACC_R);
        check(32'(ans_r.kind), 32'(OSAU_RES_IMM));
        check(ans_r.value, 32'h0000_3001);
        issue({OSAU_MODE_INCDEF, OSAU_PC_NUM}, OSAU_SIZE_L, OSAU_ACC_R);
        check(32'(ans_r.kind), 32'(OSAU_RES_IMM));
        check(ans_r.value, 32'h0000_3005);
        check(mdl.regs[15], 32'h0000_3009);
    endtask : t_pc

    task automatic t_incdef(input logic [1:0] dly);
        logic [31:0] ptr;
        ptr = {mb(32'h1013), mb(32'h1012), mb(32'h1011), mb(32'h1010)};
        mem_delay = dly;
        mdl.regs[1] = 32'h0000_1010;
        issue({OSAU_MODE_INCDEF, 4'h1}, OSAU_SIZE_W, OSAU_ACC_R);
        check(32'(ans_r.kind), 32'(OSAU_RES_ADDR));
        check(ans_r.value, ptr);
        check(mdl.regs[1], 32'h0000_1014);
    endtask : t_incdef

    task automatic t_merge();
        mdl.regs[2] = 32'h1234_5678;
        reg_write(32'hffff_abcd, 1'b1);
        check(mdl.regs[2], 32'h1234_abcd);
        reg_write(32'h0bad_f00d, 1'b0);
        check(mdl.regs[2], 32'h0bad_f00d);
    endtask : t_merge

    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_literal();
        t_register();
        t_step();
        t_pc();
        t_incdef(2'h0);
        t_incdef(2'h3);
        t_merge();
        wrap_up();
    end
endmodule : osau_unit_test
